// ===== adc_clk_div.sv
// converter clock enable generator
// assumes one clock domain; the enable is a one-cycle pulse, except undivided (fast only), where it stays high while run
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_regs.svh"
module adc_clk_div
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // control
  input  wire logic       run,
  input  wire logic       fast_sel,
  input  wire logic       slow_sel,
  // enable out
  output logic            conv_clk_en
);

  logic [1:0] cnt_r;
  logic [1:0] limit;

  // ---------------------------------------------------------------
  // divider selection
  // ---------------------------------------------------------------
  assign limit = (fast_sel && !slow_sel) ? `DIV_NONE :
                 (slow_sel && !fast_sel) ? `DIV_QUARTER : `DIV_HALF;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || !run || cnt_r >= limit)
      cnt_r <= 2'd0;
    else
      cnt_r <= cnt_r + 2'd1;
  end

  assign conv_clk_en = run && (cnt_r >= limit);

endmodule
`default_nettype wire

// ===== adc_core_model.sv
// behavioural converter core: four enabled clocks per conversion
// assumes start and abort pulses from adc_ctrl on the same clock
`timescale 1ns/10ps
`default_nettype none
module adc_core_model
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic                    clk_sys,
  input wire logic                    sys_rst,
  // commands and analog stand-in
  input wire adc_ctrl_pkg::core_cmd_t core_cmd,
  input wire logic                    stall,
  input wire logic [9:0]              sample,
  // answer
  output var adc_ctrl_pkg::core_rsp_t core_rsp
);
  logic [2:0] cnt_r;
  logic       busy_r;
  // result is only valid with done; it toggles otherwise
  always_ff @(posedge clk_sys)
  begin
    core_rsp.done <= 1'b0;
    core_rsp.result <= sys_rst ? 10'h000 : ~core_rsp.result;
    if (sys_rst || core_cmd.abort)
      busy_r <= 1'b0;
    else if (core_cmd.start)
    begin
      busy_r <= 1'b1;
      cnt_r <= 3'd0;
    end
    else if (busy_r && core_cmd.conv_clk_en && !stall)
    begin
      cnt_r <= cnt_r + 3'd1;
      if (cnt_r == 3'd3)
      begin
        busy_r <= 1'b0;
        core_rsp.done <= 1'b1;
        core_rsp.result <= sample;
      end
    end
  end
endmodule
`default_nettype wire

// ===== adc_ctrl.sv
// converter control and register front end
// assumes a single 250 MHz clock, a synchronous active high reset,
// a strobe register port and a converter core on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_regs.svh"
// Function
// - set done flag, bit 7 of control register, when a conversion completes
// - reading high result or writing control register clears done flag
// - control register is read/write except done flag, which writes ignore
// - converter clock: 00 half, fast only undivided, slow only quarter, both half
// - on bit enables and starts conversion; clearing it stops conversion
// - four-bit channel select picks analog input 0 to 15 in binary
// - high result register returns result bits 9 down to 2
// - low result register returns bits 1:0, upper bits read zero
// - all three registers reset to zero
// - control at 45h, high result at 46h, low result at 47h
// - while on, conversions repeat continuously on the selected channel
// - channel change aborts conversion, clears done, restarts on new channel
// - low result read locks results until high read or converter off
module adc_ctrl
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   sys_rst,
  // register port
  input  wire adc_ctrl_pkg::reg_req_t reg_req,
  output logic [7:0]                  reg_rdata,
  // converter core
  output adc_ctrl_pkg::core_cmd_t     core_cmd,
  output logic                        converter_on,
  input  wire adc_ctrl_pkg::core_rsp_t core_rsp,
  // interrupt
  output logic                        irq
);

  import adc_ctrl_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [7:0]  csr_r;
  logic [7:0]  csr_nxt;
  logic        done_r;
  logic        done_nxt;
  logic [7:0]  rdata_r;
  logic [1:0]  irq_stat_r;
  logic [1:0]  irq_stat_nxt;
  logic [1:0]  irq_en_r;
  conv_state_t state_r;
  conv_state_t state_nxt;

  logic        wr_csr;
  logic        wr_irq_clr;
  logic        wr_irq_en;
  logic        rd_high;
  logic        rd_low;
  logic        ch_change;
  logic        on_bit;
  logic        turn_off;
  logic        conv_clk_en;
  logic        locked;
  logic        stored;
  logic        completed;
  logic [7:0]  result_high;
  logic [7:0]  result_low;
  logic [7:0]  rd_mux;
  logic [1:0]  events;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  assign wr_csr     = reg_req.wr && hit(reg_req.addr, `CSR_OFFSET);
  assign wr_irq_clr = reg_req.wr && hit(reg_req.addr, `IRQ_CLEAR_OFFSET);
  assign wr_irq_en  = reg_req.wr && hit(reg_req.addr, `IRQ_ENABLE_OFFSET);
  assign rd_high    = reg_req.rd && hit(reg_req.addr, `RESH_OFFSET);
  assign rd_low     = reg_req.rd && hit(reg_req.addr, `RESL_OFFSET);

  assign on_bit    = csr_r[`CSR_ON_BIT];
  assign ch_change = wr_csr && on_bit && reg_req.wdata[`CSR_ON_BIT] &&
                     (reg_req.wdata[`CSR_CH_MSB:`CSR_CH_LSB] != csr_r[`CSR_CH_MSB:`CSR_CH_LSB]);
  assign turn_off  = wr_csr && !reg_req.wdata[`CSR_ON_BIT];

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  assign csr_nxt = wr_csr ? {1'b0, reg_req.wdata[6:0]} : csr_r;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      csr_r <= `CSR_RESET;
    else
      csr_r <= csr_nxt;
  end

  // ---------------------------------------------------------------
  // done flag
  // ---------------------------------------------------------------
  assign completed = (state_r == ST_BUSY) && core_rsp.done && !ch_change && on_bit;
  assign done_nxt  = completed ? 1'b1 :
                     (rd_high || wr_csr) ? 1'b0 : done_r;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      done_r <= 1'b0;
    else
      done_r <= done_nxt;
  end

  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF:
        if (on_bit)
          state_nxt = ST_START;
      ST_START:
        if (!on_bit)
          state_nxt = ST_OFF;
        else if (conv_clk_en)
          state_nxt = ST_BUSY;
      ST_BUSY:
        if (!on_bit)
          state_nxt = ST_OFF;
        else if (ch_change || core_rsp.done)
          state_nxt = ST_START;
      default:
        state_nxt = ST_OFF;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      state_r <= ST_OFF;
    else
      state_r <= state_nxt;
  end

  adc_clk_div u_div (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .run         (on_bit),
    .fast_sel    (csr_r[`CSR_FAST_BIT]),
    .slow_sel    (csr_r[`CSR_SLOW_BIT]),
    .conv_clk_en (conv_clk_en)
  );

  assign core_cmd.conv_clk_en    = conv_clk_en;
  assign core_cmd.start          = (state_r == ST_START) && on_bit && conv_clk_en;
  assign core_cmd.abort          = (state_r == ST_BUSY) && (ch_change || !on_bit);
  assign core_cmd.channel_select = csr_r[`CSR_CH_MSB:`CSR_CH_LSB];
  assign converter_on            = on_bit;

  // ---------------------------------------------------------------
  // result registers
  // ---------------------------------------------------------------
  adc_result_hold u_hold (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .capture     (completed),
    .low_read    (rd_low),
    .high_read   (rd_high),
    .conv_off    (turn_off || !on_bit),
    .result      (core_rsp.result),
    .locked      (locked),
    .result_high (result_high),
    .result_low  (result_low),
    .stored      (stored)
  );

  // ---------------------------------------------------------------
  // interrupt status
  // ---------------------------------------------------------------
  assign events       = {completed && !stored, completed};
  assign irq_stat_nxt = events | (irq_stat_r & ~(wr_irq_clr ? reg_req.wdata[1:0] : 2'b00));

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      irq_stat_r <= 2'b00;
      irq_en_r   <= 2'b00;
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      irq_en_r   <= wr_irq_en ? reg_req.wdata[1:0] : irq_en_r;
    end
  end

  assign irq = |(irq_stat_r & irq_en_r);

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  assign rd_mux = hit(reg_req.addr, `CSR_OFFSET)        ? {done_r, csr_r[6:0]} :
                  hit(reg_req.addr, `RESH_OFFSET)       ? result_high :
                  hit(reg_req.addr, `RESL_OFFSET)       ? result_low :
                  hit(reg_req.addr, `IRQ_STATUS_OFFSET) ? {6'h00, irq_stat_r} :
                  hit(reg_req.addr, `IRQ_ENABLE_OFFSET) ? {6'h00, irq_en_r} :
                  8'h00;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      rdata_r <= 8'h00;
    else if (reg_req.rd)
      rdata_r <= rd_mux;
    else
      rdata_r <= 8'h00;
  end

  assign reg_rdata = rdata_r;

endmodule
`default_nettype wire

// ===== adc_ctrl_pkg.sv
// types shared by the converter control block and its helpers
// assumes nothing beyond a SystemVerilog compiler
package adc_ctrl_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic       conv_clk_en;
    logic       start;
    logic       abort;
    logic [3:0] channel_select;
  } core_cmd_t;

  typedef struct packed {
    logic       done;
    logic [9:0] result;
  } core_rsp_t;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_START,
    ST_BUSY
  } conv_state_t;

endpackage

// ===== adc_ctrl_props.sv
// checker for the converter control block
// assumes one clock and a bind onto adc_ctrl
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl_props
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic                    clk_sys,
  input wire logic                    sys_rst,
  // watched ports
  input wire adc_ctrl_pkg::reg_req_t  reg_req,
  input wire logic [7:0]              reg_rdata,
  input wire adc_ctrl_pkg::core_cmd_t core_cmd,
  input wire logic                    converter_on,
  input wire adc_ctrl_pkg::core_rsp_t core_rsp,
  input wire logic                    irq
);
  // ------
  // properties
  // ------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  logic [1:0] sel_r;
  logic       busy_r;
  wire logic  w45 = reg_req.wr && reg_req.addr == 8'h45;
  wire logic  r45 = reg_req.rd && reg_req.addr == 8'h45;
  wire logic  r46 = reg_req.rd && reg_req.addr == 8'h46;
  always_ff @(posedge clk_sys)
    sel_r <= sys_rst ? 2'b00 : w45 ? {reg_req.wdata[4], reg_req.wdata[6]} : sel_r;
  // conversion in flight: from start until done, abort or converter off
  always_ff @(posedge clk_sys)
    busy_r <= sys_rst ? 1'b0 : core_cmd.start ? 1'b1 :
              (core_rsp.done || core_cmd.abort || !converter_on) ? 1'b0 : busy_r;
  a_reset_zero: assert property (disable iff (1'b0) sys_rst |=> reg_rdata == 8'h00 && !converter_on && !irq)
    else $error("outputs not cleared by reset");
  a_on_bit: assert property (w45 |=> converter_on == $past(reg_req.wdata[5]))
    else $error("on bit does not follow write");
  a_chan_sel: assert property (w45 |=> core_cmd.channel_select == $past(reg_req.wdata[3:0]))
    else $error("channel select does not follow write");
  a_low_upper: assert property (reg_req.rd && reg_req.addr == 8'h47 |=> reg_rdata[7:2] == 6'h00)
    else $error("low result upper bits not zero");
  a_unmapped_zero: assert property (reg_req.rd && !(reg_req.addr inside {[8'h45:8'h4a]}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_done_sets: assert property (core_rsp.done ##1 r45 |=> reg_rdata[7])
    else $error("done flag not set");
  a_high_clears: assert property (r46 && !core_rsp.done ##1 !core_rsp.done ##1 r45 && !core_rsp.done |=> !reg_rdata[7])
    else $error("done flag not cleared by high read");
  a_start_en: assert property (core_cmd.start |-> core_cmd.conv_clk_en && converter_on)
    else $error("start without clock enable");
  a_quarter_rate: assert property (disable iff (sys_rst || reg_req.wr)
    converter_on && sel_r == 2'b10 && core_cmd.conv_clk_en |=> !core_cmd.conv_clk_en [*3] ##1 core_cmd.conv_clk_en)
    else $error("quarter clock spacing wrong");
  a_chan_abort: assert property (w45 && busy_r && converter_on && reg_req.wdata[5] &&
    reg_req.wdata[3:0] != core_cmd.channel_select |-> ##[0:2] core_cmd.abort)
    else $error("channel change without abort");
  c_done: cover property (core_rsp.done);
  c_abort: cover property (core_cmd.abort);
  c_irq: cover property (irq);
endmodule
bind adc_ctrl adc_ctrl_props chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .core_cmd(core_cmd), .converter_on(converter_on), .core_rsp(core_rsp), .irq(irq));
`default_nettype wire

// ===== adc_ctrl_regs.svh
// register offsets, field positions, reset values and timing counts of the converter control block
// assumes inclusion from the design modules by bare name
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

`define CSR_OFFSET        8'h45
`define RESH_OFFSET       8'h46
`define RESL_OFFSET       8'h47
`define IRQ_STATUS_OFFSET 8'h48
`define IRQ_CLEAR_OFFSET  8'h49
`define IRQ_ENABLE_OFFSET 8'h4a

`define CSR_DONE_BIT      7
`define CSR_FAST_BIT      6
`define CSR_ON_BIT        5
`define CSR_SLOW_BIT      4
`define CSR_CH_MSB        3
`define CSR_CH_LSB        0

`define CSR_RESET         8'h00
`define RESH_RESET        8'h00
`define RESL_RESET        8'h00

`define IRQ_DONE_BIT      0
`define IRQ_LOST_BIT      1

`define DIV_HALF          2'd1
`define DIV_QUARTER       2'd3
`define DIV_NONE          2'd0

`endif

// ===== adc_result_hold.sv
// result holding registers with read lock
// assumes the capture strobe and read strobes come from the same clock
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_regs.svh"
module adc_result_hold
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // control
  input  wire logic       capture,
  input  wire logic       low_read,
  input  wire logic       high_read,
  input  wire logic       conv_off,
  input  wire logic [9:0] result,
  // status
  output logic            locked,
  output logic [7:0]      result_high,
  output logic [7:0]      result_low,
  output logic            stored
);

  localparam logic [7:0] RESL_INIT = `RESL_RESET;

  logic lock_r;
  logic [9:0] data_r;

  // ---------------------------------------------------------------
  // lock and data
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      lock_r <= 1'b0;
    else if (high_read || conv_off)
      lock_r <= 1'b0;
    else if (low_read)
      lock_r <= 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      data_r <= {`RESH_RESET, RESL_INIT[1:0]};
    else if (capture && !lock_r)
      data_r <= result;
  end

  assign stored      = capture && !lock_r;
  assign locked      = lock_r;
  assign result_high = data_r[9:2];
  assign result_low  = {6'h00, data_r[1:0]};

endmodule
`default_nettype wire

// ===== tb_adc_ctrl.sv
// self-checking bench for the converter control block
// assumes adc_core_model as the far side
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_adc_ctrl;
  import adc_ctrl_pkg::*;
  logic       clk_sys = 1'b0;
  logic       sys_rst = 1'b1;
  logic       stall = 1'b0;
  logic [9:0] sample = 10'h2b5;
  reg_req_t   req = '0;
  logic [7:0] rdata;
  core_cmd_t  cmd;
  core_rsp_t  rsp;
  logic       on;
  logic       irq;
  int         fail_count = 0;
  int         n_tests = 0;
  int         k;
  int         j;
  logic [7:0] dv [3] = '{8'h20, 8'h30, 8'h70};
  int         gp [3] = '{2, 4, 2};
  always #2 clk_sys = ~clk_sys;
  adc_ctrl uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_req(req), .reg_rdata(rdata), .core_cmd(cmd),
    .converter_on(on), .core_rsp(rsp), .irq(irq));
  adc_core_model core (.clk_sys(clk_sys), .sys_rst(sys_rst), .core_cmd(cmd), .stall(stall), .sample(sample),
    .core_rsp(rsp));
  // ------
  // tasks
  // ------
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    req <= '0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    req <= '0;
    #1 `CHK(rdata, e)
    @(posedge clk_sys);
  endtask
  task automatic wait_done;
    #1;
    for (k = 0; k < 300 && rsp.done !== 1'b1; k++)
      #4;
    if (k == 300)
    begin
      fail_count++;
      report_and_stop();
    end
    @(posedge clk_sys);
  endtask
  task automatic gap(input int e);
    int n;
    #1;
    for (k = 0; k < 20 && cmd.conv_clk_en !== 1'b1; k++)
      #4;
    if (k == 20)
    begin
      fail_count++;
      report_and_stop();
    end
    #4;
    for (n = 1; n < 20 && cmd.conv_clk_en !== 1'b1; n++)
      #4;
    `CHK(n, e)
    @(posedge clk_sys);
  endtask
  // ------
  // sequence
  // ------
  initial
  begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(8'h45, 8'h00);
    rd(8'h46, 8'h00);
    rd(8'h47, 8'h00);
    rd(8'h80, 8'h00);
    wr(8'h45, 8'h9f);
    rd(8'h45, 8'h1f);
    `CHK(cmd.channel_select, 4'hf)
    $display("test reset and control done");
    wr(8'h45, 8'h23);
    wait_done();
    stall <= 1'b1;
    rd(8'h45, 8'ha3);
    rd(8'h47, 8'h01);
    sample <= 10'h3ff;
    stall <= 1'b0;
    wait_done();
    stall <= 1'b1;
    wr(8'h46, 8'h55);
    rd(8'h46, 8'had);
    rd(8'h45, 8'h23);
    rd(8'h47, 8'h01);
    rd(8'h46, 8'had);
    stall <= 1'b0;
    wait_done();
    stall <= 1'b1;
    rd(8'h46, 8'hff);
    wr(8'h45, 8'h25);
    rd(8'h45, 8'h25);
    `CHK(cmd.channel_select, 4'h5)
    $display("test conversion done");
    for (j = 0; j < 3; j++)
    begin
      wr(8'h45, dv[j]);
      gap(gp[j]);
    end
    stall <= 1'b0;
    wr(8'h45, 8'h00);
    `CHK(on, 1'b0)
    wr(8'h49, 8'h03);
    rd(8'h48, 8'h00);
    wr(8'h45, 8'h20);
    wait_done();
    stall <= 1'b1;
    rd(8'h48, 8'h01);
    `CHK(irq, 1'b0)
    wr(8'h4a, 8'h01);
    #1 `CHK(irq, 1'b1)
    wr(8'h49, 8'h01);
    #1 `CHK(irq, 1'b0)
    $display("test divider and interrupt done");
    report_and_stop();
  end
endmodule
`default_nettype wire
